// *** shared/ostz_regs.vh ***
// register map, field positions, reset values and codes of the one-shot pulse timer
`ifndef OSTZ_REGS_VH
`define OSTZ_REGS_VH

// byte addresses
`define OSTZ_ADR_MODE      8'h80
`define OSTZ_ADR_PULSE     8'h84
`define OSTZ_ADR_PRIMARY   8'h88
`define OSTZ_ADR_PRESCALE  8'h8C
`define OSTZ_ADR_SECONDARY 8'h90
`define OSTZ_ADR_WAVE      8'h94
`define OSTZ_ADR_SOURCE    8'h98
`define OSTZ_ADR_PIN_EN    8'h9C

// timer_mode_control fields
`define OSTZ_MODE_FLD_HI   5
`define OSTZ_MODE_FLD_LO   4
`define OSTZ_WRCTL_BIT     6
`define OSTZ_RUN_BIT       7
`define OSTZ_MODE_MASK     8'hF0
`define OSTZ_MODE_ONESHOT  2'h2

// pulse_output_control fields
`define OSTZ_LEVEL_BIT     5
`define OSTZ_TRIG_EN_BIT   6
`define OSTZ_TRIG_EDGE_BIT 7
`define OSTZ_PULSE_MASK    8'hE0

// waveform_ctrl_reg and pin_enable_reg fields
`define OSTZ_START_BIT     0
`define OSTZ_PIN_EN_BIT    0

// count source codes
`define OSTZ_SRC_F1        2'h0
`define OSTZ_SRC_F2        2'h1
`define OSTZ_SRC_F8        2'h2
`define OSTZ_SRC_NBR       2'h3
`define OSTZ_DIV8_LAST     3'h7

// reset values
`define OSTZ_RST_REG8      8'h00
`define OSTZ_RST_SRC       2'h0

`endif

// *** src/ostz_src_div.v ***
// count source selection: undivided, divide-by-two, divide-by-eight or neighbour underflow
`timescale 1ns/1ns
`include "ostz_regs.vh"

module ostz_src_div (
	// clock and reset
	input  wire       clk_i,
	input  wire       rst_i,
	// selection
	input  wire [1:0] src_sel_i,
	input  wire       nbr_underflow_i,
	// enable pulse
	output reg        tick_o
);

	reg  [2:0] div_ff;

	// free-running divider; the divided rates keep their phase across a start
	always @(posedge clk_i) begin
		if (rst_i) begin
			div_ff <= 3'h0;
		end else begin
			div_ff <= div_ff + 3'h1;
		end
	end

	always @* begin
		case (src_sel_i)
			`OSTZ_SRC_F1: tick_o = 1'b1;
			`OSTZ_SRC_F2: tick_o = div_ff[0];
			`OSTZ_SRC_F8: tick_o = (div_ff == `OSTZ_DIV8_LAST);
			default:      tick_o = nbr_underflow_i;
		endcase
	end

endmodule

// *** src/ostz_sync_edge.v ***
// two-stage synchroniser for the trigger pin with rise and fall detection
`timescale 1ns/1ns

module ostz_sync_edge (
	// clock and reset
	input  wire clk_i,
	input  wire rst_i,
	// asynchronous pin
	input  wire pin_i,
	// edge pulses, one cycle each
	output wire rise_o,
	output wire fall_o
);

	reg meta_ff;
	reg sync_ff;
	reg prev_ff;

	// only sync_ff reads meta_ff, so the edge logic never sees a metastable level
	always @(posedge clk_i) begin
		if (rst_i) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
			prev_ff <= 1'b0;
		end else begin
			meta_ff <= pin_i;
			sync_ff <= meta_ff;
			prev_ff <= sync_ff;
		end
	end

	assign rise_o = sync_ff & ~prev_ff;
	assign fall_o = ~sync_ff & prev_ff;

endmodule

// *** src/ostz_top.v ***
// one-shot pulse timer: eight-bit prescaler and counter behind a classic wishbone slave
//
// Summary of operation
// - prescaler and counter step on one selected source: f1, f2, f8, neighbour.
// - count down from primary reload; underflow reloads, ends pulse, clears start bit.
// - any stop restores counter and prescaler from reloads at the same edge as it halts.
// - pulse lasts (prescaler reload + 1) times (primary reload + 1) source periods.
// - with run bit set, writing one to start bit begins the one-shot.
// - trigger edge starts only with run, pin input enable and trigger enable set.
// - trigger edges while counting are ignored but still raise the pin request.
// - counting stops on underflow reload, run bit cleared or start bit cleared.
// - timer request rises together with the end of the output pulse.
// - reload writes also load an idle counter; while counting, primary applies from next pulse, prescaler from its next reload.
// - level bit 0 gives high pulse, idle low; 1 gives low pulse, idle high.
// - trigger enable 0 leaves pin as plain input; 1 makes it a trigger.
// - trigger edge bit selects falling edge at 0, rising edge at 1.
// - mode field bits 5 and 4 select one-shot generation at binary 10.
// - the secondary reload register is never used in this mode.
// - reads of primary and prescaler return the live count values.
// - run bit 0 stops the timer, 1 allows counting.
// - in this mode the output pin carries the pulse.
// - counter and prescaler are eight bits, each sharing its reload's address.
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ns
`include "ostz_regs.vh"

module ostz_top (
	// clock and reset
	input  wire        clk_i,
	input  wire        rst_i,
	// wishbone slave
	input  wire        cyc_i,
	input  wire        stb_i,
	input  wire        we_i,
	input  wire [7:0]  adr_i,
	input  wire [3:0]  sel_i,
	input  wire [31:0] dat_i,
	output wire [31:0] dat_o,
	output wire        ack_o,
	// pins
	input  wire        ext_trigger_pin_i,
	output wire        pulse_out_pin_o,
	output wire        pulse_out_en_o,
	// neighbour timer
	input  wire        nbr_underflow_i,
	// requests
	output wire        timer_irq_o,
	output wire        pin_irq_o
);

	localparam ST_IDLE = 2'b01;
	localparam ST_CNT  = 2'b10;

	////////////////////////////////////////////////////////////////////////////

	reg  [7:0]  mode_ctl_ff;
	reg  [7:0]  pulse_ctl_ff;
	reg  [7:0]  prim_rld_ff;
	reg  [7:0]  pre_rld_ff;
	reg  [7:0]  sec_rld_ff;
	reg  [7:0]  prim_cnt_ff;
	reg  [7:0]  pre_cnt_ff;
	reg         start_ff;
	reg         pin_en_ff;
	reg  [1:0]  src_sel_ff;
	reg  [1:0]  state_ff;
	reg         out_ff;
	reg         tirq_ff;
	reg         pirq_ff;
	reg         ack_ff;
	reg  [31:0] dat_ff;
	reg         en_ff;

	reg  [7:0]  nxt_mode_ctl;
	reg  [7:0]  nxt_pulse_ctl;
	reg  [7:0]  nxt_prim_rld;
	reg  [7:0]  nxt_pre_rld;
	reg  [7:0]  nxt_sec_rld;
	reg  [7:0]  nxt_prim_cnt;
	reg  [7:0]  nxt_pre_cnt;
	reg         nxt_start;
	reg         nxt_pin_en;
	reg  [1:0]  nxt_src_sel;
	reg  [1:0]  nxt_state;
	reg         nxt_out;
	reg         nxt_tirq;
	reg         nxt_pirq;
	reg  [31:0] nxt_dat;
	reg         nxt_en;

	wire        tick;
	wire        trig_rise;
	wire        trig_fall;
	wire        access;
	wire        wr;
	wire        run_bit;
	wire        op_ok;
	wire        level;
	wire        act_edge;
	wire        trig_ok;
	wire        sw_start;
	wire        sw_stop;
	wire        counting;

	////////////////////////////////////////////////////////////////////////////
	// count source and trigger pin

	ostz_src_div u_src (
		.clk_i           (clk_i),
		.rst_i           (rst_i),
		.src_sel_i       (src_sel_ff),
		.nbr_underflow_i (nbr_underflow_i),
		.tick_o          (tick)
	);

	ostz_sync_edge u_trig (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.pin_i  (ext_trigger_pin_i),
		.rise_o (trig_rise),
		.fall_o (trig_fall)
	);

	////////////////////////////////////////////////////////////////////////////
	// decode

	// ack answers one cycle after the request; unmapped reads give zero
	assign access   = cyc_i & stb_i & ~ack_ff;
	assign wr       = access & we_i & sel_i[0];
	assign run_bit  = mode_ctl_ff[`OSTZ_RUN_BIT];
	assign level    = pulse_ctl_ff[`OSTZ_LEVEL_BIT];
	assign counting = state_ff[1];

	// other mode codes leave the block idle; only one-shot generation exists here
	assign op_ok = (mode_ctl_ff[`OSTZ_MODE_FLD_HI:`OSTZ_MODE_FLD_LO] == `OSTZ_MODE_ONESHOT);

	assign act_edge = pulse_ctl_ff[`OSTZ_TRIG_EDGE_BIT] ? trig_rise : trig_fall;

	assign trig_ok = act_edge & run_bit & pin_en_ff
		& pulse_ctl_ff[`OSTZ_TRIG_EN_BIT] & op_ok;

	assign sw_start = wr & (adr_i == `OSTZ_ADR_WAVE) & dat_i[`OSTZ_START_BIT];
	assign sw_stop  = wr & (adr_i == `OSTZ_ADR_WAVE) & ~dat_i[`OSTZ_START_BIT];

	////////////////////////////////////////////////////////////////////////////
	// next state

	always @* begin
		nxt_mode_ctl  = mode_ctl_ff;
		nxt_pulse_ctl = pulse_ctl_ff;
		nxt_prim_rld  = prim_rld_ff;
		nxt_pre_rld   = pre_rld_ff;
		nxt_sec_rld   = sec_rld_ff;
		nxt_prim_cnt  = prim_cnt_ff;
		nxt_pre_cnt   = pre_cnt_ff;
		nxt_start     = start_ff;
		nxt_pin_en    = pin_en_ff;
		nxt_src_sel   = src_sel_ff;
		nxt_state     = state_ff;
		nxt_tirq      = 1'b0;
		nxt_pirq      = 1'b0;

		// register writes
		if (wr) begin
			case (adr_i)
				`OSTZ_ADR_MODE: begin
					nxt_mode_ctl = dat_i[7:0] & `OSTZ_MODE_MASK;
				end
				`OSTZ_ADR_PULSE: begin
					nxt_pulse_ctl = dat_i[7:0] & `OSTZ_PULSE_MASK;
				end
				`OSTZ_ADR_PRIMARY: begin
					nxt_prim_rld = dat_i[7:0];
					if (!counting) begin
						nxt_prim_cnt = dat_i[7:0];
					end
				end
				`OSTZ_ADR_PRESCALE: begin
					nxt_pre_rld = dat_i[7:0];
					if (!counting) begin
						nxt_pre_cnt = dat_i[7:0];
					end
				end
				`OSTZ_ADR_SECONDARY: begin
					// stored for software only, never loaded into the counter
					nxt_sec_rld = dat_i[7:0];
				end
				`OSTZ_ADR_WAVE: begin
					nxt_start = dat_i[`OSTZ_START_BIT];
				end
				`OSTZ_ADR_SOURCE: begin
					nxt_src_sel = dat_i[1:0];
				end
				`OSTZ_ADR_PIN_EN: begin
					nxt_pin_en = dat_i[`OSTZ_PIN_EN_BIT];
				end
				default: begin
					nxt_start = start_ff;
				end
			endcase
		end

		// the pin request follows every enabled active edge, counting or not
		if (act_edge & pin_en_ff) begin
			nxt_pirq = 1'b1;
		end

		case (state_ff)
			ST_IDLE: begin
				// a write of one while the run bit is low is stored but starts nothing
				if (run_bit & op_ok & (sw_start | trig_ok)) begin
					nxt_state    = ST_CNT;
					nxt_start    = 1'b1;
					nxt_prim_cnt = prim_rld_ff;
					nxt_pre_cnt  = pre_rld_ff;
				end
			end
			ST_CNT: begin
				// trig_ok is not looked at here, so edges during the pulse are dropped
				// a stop outranks an underflow in the same cycle, so no request follows it
				if (!run_bit | sw_stop | !op_ok) begin
					nxt_state    = ST_IDLE;
					nxt_start    = 1'b0;
					nxt_prim_cnt = prim_rld_ff;
					nxt_pre_cnt  = pre_rld_ff;
				end else if (tick) begin
					if (pre_cnt_ff == 8'h00) begin
						nxt_pre_cnt = pre_rld_ff;
						if (prim_cnt_ff == 8'h00) begin
							nxt_prim_cnt = prim_rld_ff;
							nxt_start    = 1'b0;
							nxt_state    = ST_IDLE;
							nxt_tirq     = 1'b1;
						end else begin
							nxt_prim_cnt = prim_cnt_ff - 8'h01;
						end
					end else begin
						nxt_pre_cnt = pre_cnt_ff - 8'h01;
					end
				end
			end
			default: begin
				nxt_state = ST_IDLE;
				nxt_start = 1'b0;
			end
		endcase

		// pulse level follows the state; the end and the request share one edge
		nxt_out = (nxt_state == ST_CNT) ? ~level : level;

		// the enable is registered yet follows a mode write at that write's own edge
		nxt_en = (nxt_mode_ctl[`OSTZ_MODE_FLD_HI:`OSTZ_MODE_FLD_LO] == `OSTZ_MODE_ONESHOT);

		// read data
		// counter locations show the live counts, so software can watch a pulse run
		nxt_dat = 32'h0000_0000;
		case (adr_i)
			`OSTZ_ADR_MODE: begin
				nxt_dat[7:0] = mode_ctl_ff;
			end
			`OSTZ_ADR_PULSE: begin
				nxt_dat[7:0] = pulse_ctl_ff;
			end
			`OSTZ_ADR_PRIMARY: begin
				nxt_dat[7:0] = prim_cnt_ff;
			end
			`OSTZ_ADR_PRESCALE: begin
				nxt_dat[7:0] = pre_cnt_ff;
			end
			`OSTZ_ADR_SECONDARY: begin
				nxt_dat[7:0] = sec_rld_ff;
			end
			`OSTZ_ADR_WAVE: begin
				nxt_dat[`OSTZ_START_BIT] = start_ff;
			end
			`OSTZ_ADR_SOURCE: begin
				nxt_dat[1:0] = src_sel_ff;
			end
			`OSTZ_ADR_PIN_EN: begin
				nxt_dat[`OSTZ_PIN_EN_BIT] = pin_en_ff;
			end
			default: begin
				nxt_dat = 32'h0000_0000;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// registers

	always @(posedge clk_i) begin
		if (rst_i) begin
			mode_ctl_ff  <= `OSTZ_RST_REG8;
			pulse_ctl_ff <= `OSTZ_RST_REG8;
			prim_rld_ff  <= `OSTZ_RST_REG8;
			pre_rld_ff   <= `OSTZ_RST_REG8;
			sec_rld_ff   <= `OSTZ_RST_REG8;
			prim_cnt_ff  <= `OSTZ_RST_REG8;
			pre_cnt_ff   <= `OSTZ_RST_REG8;
			start_ff     <= 1'b0;
			pin_en_ff    <= 1'b0;
			src_sel_ff   <= `OSTZ_RST_SRC;
			state_ff     <= ST_IDLE;
			out_ff       <= 1'b0;
			tirq_ff      <= 1'b0;
			pirq_ff      <= 1'b0;
			ack_ff       <= 1'b0;
			dat_ff       <= 32'h0000_0000;
			en_ff        <= 1'b0;
		end else begin
			mode_ctl_ff  <= nxt_mode_ctl;
			pulse_ctl_ff <= nxt_pulse_ctl;
			prim_rld_ff  <= nxt_prim_rld;
			pre_rld_ff   <= nxt_pre_rld;
			sec_rld_ff   <= nxt_sec_rld;
			prim_cnt_ff  <= nxt_prim_cnt;
			pre_cnt_ff   <= nxt_pre_cnt;
			start_ff     <= nxt_start;
			pin_en_ff    <= nxt_pin_en;
			src_sel_ff   <= nxt_src_sel;
			state_ff     <= nxt_state;
			out_ff       <= nxt_out;
			tirq_ff      <= nxt_tirq;
			pirq_ff      <= nxt_pirq;
			ack_ff       <= cyc_i & stb_i & ~ack_ff;
			en_ff        <= nxt_en;
			if (access & ~we_i) begin
				dat_ff <= nxt_dat;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign dat_o           = dat_ff;
	assign ack_o           = ack_ff;
	assign pulse_out_pin_o = out_ff;
	assign pulse_out_en_o  = en_ff;
	assign timer_irq_o     = tirq_ff;
	assign pin_irq_o       = pirq_ff;

endmodule

// *** testbench/ostz_far_side.sv ***
// far-side model: trigger pin source and neighbour timer
`timescale 1ns/1ns
module ostz_far_side (
	// clock
	input  wire  clk_i,
	// modelled lines
	output logic trig_pin_o,
	output logic nbr_underflow_o
);
	logic [1:0] div_ff;
	initial begin
		div_ff = 2'h0;
		trig_pin_o = 1'b0;
		nbr_underflow_o = 1'b0;
	end
	// free-running neighbour, one underflow every four clocks
	always @(posedge clk_i) begin
		div_ff <= div_ff + 2'h1;
		nbr_underflow_o <= (div_ff == 2'h3);
	end
	// level held long enough for the synchroniser
	task automatic drive(input logic lvl, input int hold);
		@(posedge clk_i);
		trig_pin_o <= lvl;
		repeat (hold) @(posedge clk_i);
	endtask
endmodule

// *** testbench/ostz_checker_assertions.sv ***
// port checks of the one-shot pulse timer
`timescale 1ns/1ns
module ostz_checker (
	// clock and reset
	input wire        clk_i,
	input wire        rst_i,
	// bus
	input wire        cyc_i,
	input wire        stb_i,
	input wire        we_i,
	input wire [7:0]  adr_i,
	input wire [3:0]  sel_i,
	input wire [31:0] dat_i,
	input wire [31:0] dat_o,
	input wire        ack_o,
	// pins
	input wire        pulse_out_pin_o,
	input wire        pulse_out_en_o,
	input wire        timer_irq_o,
	input wire        pin_irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire  wr_w = cyc_i & stb_i & ~ack_o & we_i & sel_i[0];
	logic lvl_ff;
	// idle level shadow, so the pin is judged without internals
	always @(posedge clk_i) begin
		if (rst_i)
			lvl_ff <= 1'b0;
		else if (wr_w && adr_i == 8'h84)
			lvl_ff <= dat_i[5];
	end
	////////////////////////////////////////
	property p_ack_lat;
		cyc_i && stb_i && !ack_o |=> ack_o;
	endproperty
	a_ack_lat: assert property (p_ack_lat) else $error("ack late");
	property p_ack_one;
		ack_o |=> !ack_o;
	endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack too long");
	property p_rd_hi;
		ack_o && !we_i |-> dat_o[31:8] == 24'h0;
	endproperty
	a_rd_hi: assert property (p_rd_hi) else $error("upper read bits set");
	property p_irq_end;
		$rose(timer_irq_o) |-> $changed(pulse_out_pin_o) && pulse_out_pin_o == lvl_ff;
	endproperty
	a_irq_end: assert property (p_irq_end) else $error("irq apart from pulse end");
	property p_pin_one;
		pin_irq_o |=> !pin_irq_o;
	endproperty
	a_pin_one: assert property (p_pin_one) else $error("pin request too long");
	property p_mode;
		wr_w && adr_i == 8'h80 |=> pulse_out_en_o == (dat_i[5:4] == 2'h2);
	endproperty
	a_mode: assert property (p_mode) else $error("output enable off mode");
	property p_stop;
		wr_w && adr_i == 8'h94 && !dat_i[0] |=> ##1 pulse_out_pin_o == lvl_ff;
	endproperty
	a_stop: assert property (p_stop) else $error("pulse survives stop");
	property p_run_stop;
		wr_w && adr_i == 8'h80 && !dat_i[7] |=> ##1 pulse_out_pin_o == lvl_ff && !timer_irq_o;
	endproperty
	a_run_stop: assert property (p_run_stop) else $error("pulse survives run off");
endmodule
bind ostz_top ostz_checker chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
	.dat_o, .ack_o, .pulse_out_pin_o, .pulse_out_en_o, .timer_irq_o, .pin_irq_o);

// *** testbench/oneshot_pulse_timer_bench.sv ***
// bench of the one-shot pulse timer
`timescale 1ns/1ns
module oneshot_pulse_timer_bench;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc_i = 1'b0;
	logic        stb_i = 1'b0;
	logic        we_i = 1'b0;
	logic [7:0]  adr_i = 8'h00;
	logic [31:0] dat_i = 32'h0;
	logic [31:0] q;
	int          n;
	int          pcnt = 0;
	int          cycles = 0;
	int          mismatches = 0;
	int          samples_checked = 0;
	int          per [4] = '{1, 2, 8, 4};
	wire  [31:0] dat_o;
	wire         ack_o, pin_w, out_w, en_w, nbr_w, tirq_w, pirq_w;
	initial forever #10 clk_i = ~clk_i;
	ostz_top dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_i, .dat_o, .ack_o,
		.sel_i(4'hF), .ext_trigger_pin_i(pin_w), .pulse_out_pin_o(out_w),
		.pulse_out_en_o(en_w), .nbr_underflow_i(nbr_w), .timer_irq_o(tirq_w),
		.pin_irq_o(pirq_w));
	ostz_far_side far (.clk_i, .trig_pin_o(pin_w), .nbr_underflow_o(nbr_w));
	////////////////////////////////////////
	task automatic test_done;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// pin requests counted; the run is cut short if it hangs
	always @(posedge clk_i) begin
		cycles++;
		if (pirq_w === 1'b1)
			pcnt++;
		if (cycles == 20000) begin
			mismatches++;
			test_done();
		end
	end
	task automatic chk(input string what, input logic [31:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(what, q, e);
	endtask
	// waits for the active level, then counts clocks while it stands
	task automatic meas(input logic act);
		n = 0;
		while (out_w !== act && n < 40) begin
			@(posedge clk_i);
			n++;
		end
		n = 0;
		while (out_w === act && n < 900) begin
			@(posedge clk_i);
			n++;
		end
	endtask
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		rchk("mode", 8'h80, 32'h0);
		rchk("pulse", 8'h84, 32'h0);
		rchk("unmapped", 8'hA4, 32'h0);
		wr(8'h90, 32'h5A);
		rchk("secondary", 8'h90, 32'h5A);
		wr(8'h80, 32'hEF);
		rchk("mode", 8'h80, 32'hE0);
		chk("enable", en_w, 32'h1);
		wr(8'h88, 32'h3);
		wr(8'h8C, 32'h2);
		for (int s = 0; s < 4; s++) begin
			wr(8'h98, 32'(s));
			wr(8'h94, 32'h1);
			meas(1'b1);
			chk("len", 32'(n > 11 * per[s] && n < 13 * per[s]), 32'h1);
			chk("irq", tirq_w, 32'h1);
			rchk("start", 8'h94, 32'h0);
		end
		$display("sources done");
		wr(8'h98, 32'h0);
		wr(8'h94, 32'h1);
		wr(8'h88, 32'h0);
		meas(1'b1);
		chk("rest", n, 32'd9);
		wr(8'h94, 32'h1);
		meas(1'b1);
		chk("new len", n, 32'd3);
		wr(8'h88, 32'h3);
		wr(8'h94, 32'h1);
		rchk("live prescale", 8'h8C, 32'h0);
		wr(8'h94, 32'h0);
		rchk("count", 8'h88, 32'h3);
		rchk("prescale", 8'h8C, 32'h2);
		chk("stopped", out_w, 32'h0);
		wr(8'h94, 32'h1);
		wr(8'h80, 32'h20);
		@(posedge clk_i);
		chk("run off", out_w, 32'h0);
		wr(8'h94, 32'h1);
		repeat (4) @(posedge clk_i);
		chk("no start", out_w, 32'h0);
		wr(8'h94, 32'h0);
		wr(8'h80, 32'hD0);
		chk("mode en", en_w, 32'h0);
		wr(8'h94, 32'h1);
		repeat (4) @(posedge clk_i);
		chk("mode off", out_w, 32'h0);
		wr(8'h94, 32'h0);
		wr(8'h80, 32'hE0);
		$display("stops done");
		wr(8'h88, 32'hF);
		wr(8'h9C, 32'h1);
		wr(8'h84, 32'hA0);
		far.drive(1'b1, 8);
		chk("trig off", out_w, 32'h1);
		far.drive(1'b0, 8);
		wr(8'h84, 32'hE0);
		pcnt = 0;
		fork
			meas(1'b0);
			begin
				far.drive(1'b1, 8);
				far.drive(1'b0, 8);
				far.drive(1'b1, 8);
			end
		join
		chk("trig len", n, 32'd48);
		chk("pin req", pcnt, 32'd2);
		wr(8'h84, 32'h60);
		fork
			meas(1'b0);
			far.drive(1'b0, 8);
		join
		chk("fall len", n, 32'd48);
		wr(8'h9C, 32'h0);
		far.drive(1'b1, 8);
		far.drive(1'b0, 8);
		chk("pin off", out_w, 32'h1);
		$display("triggers done");
		test_done();
	end
endmodule
